/* hw/charge_safety_supervisor.sv */
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "charge_safety_cfg.svh"
module charge_safety_supervisor
    import charge_safety_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_MS * `CLK_MHZ * `KHZ_PER_MHZ,
    parameter int unsigned FAST_TICKS = `FAST_TIMER_MIN * `SEC_PER_MIN * `MS_PER_SEC / `TICK_MS,
    parameter int unsigned PRE_TICKS = `PRE_TIMER_MIN * `SEC_PER_MIN * `MS_PER_SEC / `TICK_MS,
    parameter int unsigned IRQ_CYCLES = `IRQ_PULSE_US * `CLK_MHZ
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tsColdCmp,
    input wire logic tsCoolCmp,
    input wire logic tsWarmCmp,
    input wire logic tsHotCmp,
    input wire logic otgColdCmp,
    input wire logic otgHotCmp,
    input wire logic boostSwitching,
    input wire logic buckSwitching,
    input wire logic otgMode,
    input wire logic charge_enable_n,
    input wire logic batBelowVreg,
    input wire logic batBelowLow,
    input wire logic rechargeEvent,
    input wire logic vinRegActive,
    input wire logic iinRegActive,
    input wire logic thermRegActive,
    input wire logic supplementActive,
    input wire logic chargeFault,
    input wire logic sysFloorActive,
    input wire logic [2:0] sourceTypeIn,
    output logic chargeCurrentOn,
    output logic [1:0] chargeVoltCode,
    output logic [6:0] currentScalePct,
    output logic terminationEnable,
    output logic batSwitchOn,
    output logic otgOutputEnable,
    output logic [2:0] inputSourceStatus,
    output logic [2:0] thermistorZoneStatus,
    output logic [3:0] sysFloorSetting,
    output logic host_irq_n
);
    // control registers
    logic chargeAllow_r;
    logic timerEnable_r;
    logic slowCountEnable_r;
    logic termEnable_r;
    logic [1:0] warmVoltageSelect_r;
    logic [1:0] coolCurrentSelect_r;
    logic [3:0] sysFloorSetting_r;
    // state
    zone_e zone_r;
    logic charging_r;
    logic [31:0] tickCnt_r;
    logic [31:0] irqCnt_r;
    logic [31:0] irqCnt_nxt;
    logic allowPrev_r;
    logic pinPrev_r;
    logic lowPrev_r;
    logic faultPrev_r;
    logic [2:0] tzsPrev_r;
    logic [2:0] issPrev_r;
    logic iinStatus_r;
    logic vinStatus_r;
    logic floorStatus_r;
    logic timerFault_r;
    // combinational terms
    logic tick;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic regulation;
    logic tempProtect;
    logic inWindow;
    logic tempOk;
    logic allowed;
    logic startOk;
    logic zoneSuspend;
    logic pauseTimers;
    logic restartTimers;
    logic timerFault;
    logic preExpired;
    logic fastExpired;
    logic otgFault;
    logic irqEvent;
    zone_e zone_nxt;
    logic [31:0] ctrlView;
    logic [31:0] statusView;

    generate
        if (TICK_CYCLES < 2 || IRQ_CYCLES < 8) begin : g_chk
            $error("tick needs 2 cycles and irq pulse 8 cycles at least");
        end
    endgenerate

    // apb decode; zero wait states, so the access phase always completes
    assign mapped = paddr == `REG_CTRL || paddr == `REG_STATUS;
    assign wrEn = psel && penable && pwrite && paddr == `REG_CTRL;
    assign rdEn = psel && !penable && !pwrite;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;

    assign regulation = vinRegActive || iinRegActive || thermRegActive;

    // control register writes, byte lanes honoured
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chargeAllow_r <= `RST_ALLOW;
            timerEnable_r <= `RST_TMR_EN;
            slowCountEnable_r <= `RST_SLOW;
            termEnable_r <= `RST_TERM;
            warmVoltageSelect_r <= `RST_WARMV;
            coolCurrentSelect_r <= `RST_COOLI;
            sysFloorSetting_r <= `RST_FLOOR;
        end else if (wrEn) begin
            if (pstrb[0]) begin
                chargeAllow_r <= pwdata[`CTRL_ALLOW];
                timerEnable_r <= pwdata[`CTRL_TMR_EN];
                if (pwdata[`CTRL_SLOW] || !(slowCountEnable_r && regulation)) begin
                    slowCountEnable_r <= pwdata[`CTRL_SLOW];
                end
                termEnable_r <= pwdata[`CTRL_TERM];
                warmVoltageSelect_r <= pwdata[`CTRL_WARMV_LSB +: 2];
                coolCurrentSelect_r <= pwdata[`CTRL_COOLI_LSB +: 2];
            end
            if (pstrb[1]) begin
                sysFloorSetting_r <= pwdata[`CTRL_FLOOR_MSB:`CTRL_FLOOR_LSB];
            end
        end
    end

    assign ctrlView = {20'h00000, sysFloorSetting_r, coolCurrentSelect_r, warmVoltageSelect_r,
        termEnable_r, slowCountEnable_r, timerEnable_r, chargeAllow_r};
    assign statusView = {17'h00000, inputSourceStatus, 1'b0, thermistorZoneStatus, 3'h0, charging_r,
        floorStatus_r, vinStatus_r, iinStatus_r, timerFault_r};

    // read data captured in the setup phase so prdata comes from a flop
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
        end else if (rdEn) begin
            prdata <= paddr == `REG_CTRL ? ctrlView : paddr == `REG_STATUS ? statusView : 32'h00000000;
        end
    end

    // tick prescaler; one slow tick keeps the timers narrow
    assign tick = tickCnt_r == TICK_CYCLES - 1;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tickCnt_r <= 32'h00000000;
        end else begin
            tickCnt_r <= tick ? 32'h00000000 : tickCnt_r + 32'h00000001;
        end
    end

    always_comb begin
        if (tsColdCmp) begin
            zone_nxt = ZONE_COLD;
        end else if (tsHotCmp) begin
            zone_nxt = ZONE_HOT;
        end else if (tsCoolCmp) begin
            zone_nxt = ZONE_COOL;
        end else if (tsWarmCmp) begin
            zone_nxt = ZONE_WARM;
        end else begin
            zone_nxt = ZONE_NORMAL;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            zone_r <= ZONE_NORMAL;
        end else if (tick) begin
            zone_r <= zone_nxt;
        end
    end

    // protection only while a converter switches
    assign tempProtect = boostSwitching || buckSwitching;
    assign inWindow = zone_r != ZONE_COLD && zone_r != ZONE_HOT;
    assign tempOk = !tempProtect || inWindow;
    assign allowed = chargeAllow_r && !charge_enable_n;
    assign timerFault = preExpired || fastExpired;
    assign startOk = allowed && boostSwitching && tempOk && !timerFault && batBelowVreg;
    // suspend codes in warm and cool zones
    assign zoneSuspend = (zone_r == ZONE_WARM && warmVoltageSelect_r == `WARMV_SUSP)
        || (zone_r == ZONE_COOL && coolCurrentSelect_r == `COOLI_SUSP);

    // charge cycle: ends on disable or timer fault, temperature only suspends it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            charging_r <= 1'b0;
        end else if (!allowed || timerFault) begin
            charging_r <= 1'b0;
        end else if (!charging_r && startOk) begin
            charging_r <= 1'b1;
        end
    end

    // edge history for restart detection
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // history starts at the reset levels so release brings no false edge
            allowPrev_r <= `RST_ALLOW;
            pinPrev_r <= 1'b1;
            lowPrev_r <= 1'b0;
        end else begin
            allowPrev_r <= chargeAllow_r;
            pinPrev_r <= charge_enable_n;
            lowPrev_r <= batBelowLow;
        end
    end

    // restart on enable, pin, recharge or phase change
    assign restartTimers = allowPrev_r != chargeAllow_r || pinPrev_r != charge_enable_n
        || lowPrev_r != batBelowLow || (rechargeEvent && !timerFault);
    // hot or cold suspend also counts as a charging fault
    assign pauseTimers = supplementActive || chargeFault || !tempOk;

    // pre-charge timer runs below the low threshold
    safety_timer #(
        .LIMIT(PRE_TICKS)
    ) u_pre_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .tick(tick),
        .enable(timerEnable_r),
        .run(charging_r && batBelowLow),
        .pause(pauseTimers),
        .half(regulation && slowCountEnable_r),
        .restart(restartTimers),
        .expired(preExpired)
    );

    // fast timer; half only with slow-count set
    safety_timer #(
        .LIMIT(FAST_TICKS)
    ) u_fast_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .tick(tick),
        .enable(timerEnable_r),
        .run(charging_r && !batBelowLow),
        .pause(pauseTimers),
        .half(regulation && slowCountEnable_r),
        .restart(restartTimers),
        .expired(fastExpired)
    );

    // otg temperature fault while output is asked for
    assign otgFault = otgMode && (otgColdCmp || otgHotCmp);

    // registered outputs towards the analog side
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chargeCurrentOn <= 1'b0;
            chargeVoltCode <= `VOUT_VREG;
            currentScalePct <= `PCT_100;
            terminationEnable <= `RST_TERM;
            batSwitchOn <= 1'b1;
            otgOutputEnable <= 1'b0;
        end else begin
            chargeCurrentOn <= charging_r && tempOk && !zoneSuspend && !supplementActive && !chargeFault;
            if (zone_r == ZONE_WARM && warmVoltageSelect_r == `WARMV_8V0) begin
                chargeVoltCode <= `VOUT_8V0;
            end else if (zone_r == ZONE_WARM && warmVoltageSelect_r == `WARMV_8V3) begin
                chargeVoltCode <= `VOUT_8V3;
            end else begin
                chargeVoltCode <= `VOUT_VREG;
            end
            if (zone_r != ZONE_COOL || coolCurrentSelect_r == `COOLI_100) begin
                currentScalePct <= `PCT_100;
            end else if (coolCurrentSelect_r == `COOLI_40) begin
                currentScalePct <= `PCT_40;
            end else if (coolCurrentSelect_r == `COOLI_20) begin
                currentScalePct <= `PCT_20;
            end else begin
                currentScalePct <= `PCT_0;
            end
            terminationEnable <= termEnable_r;
            batSwitchOn <= !timerFault;
            otgOutputEnable <= otgMode && !otgFault;
        end
    end

    // status fields and limit bits
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inputSourceStatus <= `ISS_NONE;
            thermistorZoneStatus <= `TZS_NORMAL;
            iinStatus_r <= 1'b0;
            vinStatus_r <= 1'b0;
            floorStatus_r <= 1'b0;
            timerFault_r <= 1'b0;
        end else begin
            if (otgMode) begin
                inputSourceStatus <= otgFault ? `ISS_NONE : `ISS_OTG;
            end else begin
                inputSourceStatus <= sourceTypeIn;
            end
            if (otgMode) begin
                thermistorZoneStatus <= !otgFault ? `TZS_NORMAL : otgColdCmp ? `TZS_COLD : `TZS_HOT;
            end else begin
                unique case (zone_r)
                    ZONE_COLD: thermistorZoneStatus <= `TZS_COLD;
                    ZONE_COOL: thermistorZoneStatus <= `TZS_COOL;
                    ZONE_NORMAL: thermistorZoneStatus <= `TZS_NORMAL;
                    ZONE_WARM: thermistorZoneStatus <= `TZS_WARM;
                    ZONE_HOT: thermistorZoneStatus <= `TZS_HOT;
                    default: thermistorZoneStatus <= `TZS_NORMAL;
                endcase
            end
            iinStatus_r <= iinRegActive;
            vinStatus_r <= vinRegActive;
            floorStatus_r <= sysFloorActive;
            timerFault_r <= timerFault;
        end
    end

    // history for irq events
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            faultPrev_r <= 1'b0;
            tzsPrev_r <= `TZS_NORMAL;
            issPrev_r <= `ISS_NONE;
        end else begin
            faultPrev_r <= timerFault_r;
            tzsPrev_r <= thermistorZoneStatus;
            issPrev_r <= inputSourceStatus;
        end
    end

    // expiry or a zone or source status change starts a low pulse; a new event restarts it
    assign irqEvent = (timerFault_r && !faultPrev_r) || tzsPrev_r != thermistorZoneStatus
        || issPrev_r != inputSourceStatus;
    always_comb begin
        if (irqEvent) begin
            irqCnt_nxt = IRQ_CYCLES;
        end else if (irqCnt_r != 32'h00000000) begin
            irqCnt_nxt = irqCnt_r - 32'h00000001;
        end else begin
            irqCnt_nxt = 32'h00000000;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqCnt_r <= 32'h00000000;
        end else begin
            irqCnt_r <= irqCnt_nxt;
        end
    end
    assign host_irq_n = irqCnt_r == 32'h00000000;
    assign sysFloorSetting = sysFloorSetting_r;

    a_start_window: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(charging_r) |-> $past(tempOk) && $past(allowed)) else $error("charge began outside window");
    a_suspend_hot: assert property (@(posedge mclk) disable iff (!arst_n)
        tempProtect && !inWindow |=> !chargeCurrentOn) else $error("current on outside window");
    a_warm_volt: assert property (@(posedge mclk) disable iff (!arst_n)
        zone_r == ZONE_WARM && warmVoltageSelect_r == `WARMV_8V3 |=> chargeVoltCode == `VOUT_8V3)
        else $error("warm voltage not applied");
    a_cool_scale: assert property (@(posedge mclk) disable iff (!arst_n)
        zone_r == ZONE_COOL && coolCurrentSelect_r == `COOLI_20 |=> currentScalePct == `PCT_20)
        else $error("cool scale not applied");
    a_otg_suspend: assert property (@(posedge mclk) disable iff (!arst_n)
        otgFault |=> !otgOutputEnable && inputSourceStatus == `ISS_NONE && thermistorZoneStatus != `TZS_NORMAL)
        else $error("otg not suspended on fault");
    a_expiry_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(timerFault) |-> ##2 !host_irq_n [*8]) else $error("no irq pulse on expiry");
    a_fault_blocks: assert property (@(posedge mclk) disable iff (!arst_n)
        timerFault |=> !charging_r && !batSwitchOn) else $error("charging with timer fault");
    a_limit_bits: assert property (@(posedge mclk) disable iff (!arst_n)
        ##1 iinStatus_r == $past(iinRegActive) && floorStatus_r == $past(sysFloorActive))
        else $error("limit status lags its source");
endmodule

/* hw/charge_safety_cfg.svh */
`ifndef CHARGE_SAFETY_CFG_SVH
`define CHARGE_SAFETY_CFG_SVH

// clock and timing (figures in their own units)
`define CLK_MHZ 200
`define KHZ_PER_MHZ 1000
`define TICK_MS 1000
`define MS_PER_SEC 1000
`define SEC_PER_MIN 60
`define FAST_TIMER_MIN 990
`define PRE_TIMER_MIN 120
`define IRQ_PULSE_US 256

// apb register map (byte addresses)
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04

// control register fields
`define CTRL_ALLOW 0
`define CTRL_TMR_EN 1
`define CTRL_SLOW 2
`define CTRL_TERM 3
`define CTRL_WARMV_LSB 4
`define CTRL_COOLI_LSB 6
`define CTRL_FLOOR_LSB 8
`define CTRL_FLOOR_MSB 11

// control reset values
`define RST_ALLOW 1'b1
`define RST_TMR_EN 1'b1
`define RST_SLOW 1'b1
`define RST_TERM 1'b1
`define RST_WARMV 2'h0
`define RST_COOLI 2'h1
`define RST_FLOOR 4'h2

// status register fields
`define STS_EXPIRY 0
`define STS_IINLIM 1
`define STS_VINLIM 2
`define STS_FLOOR 3
`define STS_CHARGING 4
`define STS_TZS_LSB 8
`define STS_ISS_LSB 12

// warm voltage select codes and voltage target codes
`define WARMV_8V0 2'h0
`define WARMV_8V3 2'h1
`define WARMV_VREG 2'h2
`define WARMV_SUSP 2'h3
`define VOUT_VREG 2'h0
`define VOUT_8V0 2'h1
`define VOUT_8V3 2'h2

// cool current select codes and percentages
`define COOLI_SUSP 2'h0
`define COOLI_20 2'h1
`define COOLI_40 2'h2
`define COOLI_100 2'h3
`define PCT_0 7'h00
`define PCT_20 7'h14
`define PCT_40 7'h28
`define PCT_100 7'h64

// status field codes
`define ISS_NONE 3'h0
`define ISS_OTG 3'h7
`define TZS_NORMAL 3'h0
`define TZS_WARM 3'h2
`define TZS_COOL 3'h3
`define TZS_COLD 3'h5
`define TZS_HOT 3'h6
`endif

/* hw/charge_safety_pkg.sv */
package charge_safety_pkg;
    // battery temperature zones, gray along cold to hot
    typedef enum logic [2:0] {
        ZONE_COLD = 3'h0,
        ZONE_COOL = 3'h1,
        ZONE_NORMAL = 3'h3,
        ZONE_WARM = 3'h2,
        ZONE_HOT = 3'h6
    } zone_e;
endpackage

/* hw/safety_timer.sv */
`timescale 1ns/1ps
module safety_timer #(
    parameter int unsigned LIMIT = 2
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic run,
    input wire logic pause,
    input wire logic half,
    input wire logic restart,
    output logic expired
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    logic [CW-1:0] count_r;
    logic alt_r;
    logic expired_r;
    logic advance;

    generate
        if (LIMIT < 2) begin : g_chk
            $error("safety_timer LIMIT must be at least 2");
        end
    endgenerate

    assign advance = tick && run && !pause && !expired_r && (!half || alt_r);
    assign expired = expired_r;

    // count, hold while paused, clear on restart
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
            alt_r <= 1'b0;
            expired_r <= 1'b0;
        end else if (!enable || restart) begin
            count_r <= '0;
            alt_r <= 1'b0;
            expired_r <= 1'b0;
        end else begin
            if (tick && run && !pause && half) begin
                alt_r <= !alt_r;
            end
            if (advance) begin
                count_r <= count_r + CW'(1);
                if (count_r == CW'(LIMIT - 1)) begin
                    expired_r <= 1'b1;
                end
            end
        end
    end

    a_timer_off: assert property (@(posedge mclk) disable iff (!arst_n)
        !enable |=> count_r == '0 && !expired_r) else $error("timer not cleared when disabled");
    // half rate needs two ticks per step
    a_half_rate: assert property (@(posedge mclk) disable iff (!arst_n)
        tick && run && !pause && half && !alt_r && enable && !restart |=> $stable(count_r))
        else $error("timer advanced on skipped tick");
    a_pause_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        pause && enable && !restart |=> $stable(count_r)) else $error("timer moved while paused");
endmodule

/* verif/irq_watch.sv */
`timescale 1ns/1ps
// host side: counts interrupt pulses, keeps the last low width
module irq_watch (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic host_irq_n,
    output int pulses,
    output int width
);
    int run;
    // a retriggered pulse shows up as one long width
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pulses <= 0;
            width <= 0;
            run <= 0;
        end else if (!host_irq_n) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulses <= pulses + 1;
            width <= run;
            run <= 0;
        end
    end
endmodule

/* verif/charge_safety_supervisor_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module charge_safety_supervisor_tb_top;
    logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic tsCold = 1'b0, tsCool = 1'b0, tsWarm = 1'b0, tsHot = 1'b0, otgHot = 1'b0, boost = 1'b1, buck = 1'b1;
    logic supp = 1'b0, fault = 1'b0, otgCold = 1'b0;
    logic [3:0] strb = 4'hF;
    logic [2:0] srcType = 3'h3;
    logic otgMode = 1'b0, chgEnN = 1'b1, belowVreg = 1'b1, belowLow = 1'b0, recharge = 1'b0;
    logic vinReg = 1'b0, iinReg = 1'b0, thermReg = 1'b0, floorAct = 1'b0;
    logic chargeOn, termEn, batSw, otgEn, irqN;
    logic [1:0] voltCode;
    logic [6:0] pct;
    logic [2:0] iss, tzs;
    logic [3:0] floorSet;
    logic [6:0] pctTab [4] = '{7'h00, 7'h14, 7'h28, 7'h64};
    logic [1:0] voltTab [3] = '{2'h1, 2'h2, 2'h0};
    int failures = 0, compares = 0, cycles = 0, pulses, width, base;

    always #2.5 mclk = ~mclk;

    charge_safety_supervisor #(.TICK_CYCLES(4), .FAST_TICKS(20), .PRE_TICKS(10), .IRQ_CYCLES(8))
    u_charge_safety_supervisor (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tsColdCmp(tsCold), .tsCoolCmp(tsCool), .tsWarmCmp(tsWarm), .tsHotCmp(tsHot),
        .otgColdCmp(otgCold), .otgHotCmp(otgHot), .boostSwitching(boost), .buckSwitching(buck),
        .otgMode(otgMode), .charge_enable_n(chgEnN), .batBelowVreg(belowVreg), .batBelowLow(belowLow),
        .rechargeEvent(recharge), .vinRegActive(vinReg), .iinRegActive(iinReg), .thermRegActive(thermReg),
        .supplementActive(supp), .chargeFault(fault), .sysFloorActive(floorAct), .sourceTypeIn(srcType),
        .chargeCurrentOn(chargeOn), .chargeVoltCode(voltCode), .currentScalePct(pct),
        .terminationEnable(termEn), .batSwitchOn(batSw), .otgOutputEnable(otgEn),
        .inputSourceStatus(iss), .thermistorZoneStatus(tzs), .sysFloorSetting(floorSet), .host_irq_n(irqN));

    irq_watch u_irq_watch (.mclk(mclk), .arst_n(arst_n), .host_irq_n(irqN), .pulses(pulses), .width(width));

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one apb transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic restart();
        chgEnN <= 1'b1;
        wt(3);
        chgEnN <= 1'b0;
    endtask

    task automatic waitOff(input int n);
        for (int i = 0; i < n && batSw !== 1'b0; i++) @(posedge mclk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, well above the planned run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        wt(4);
        arst_n <= 1'b1;
        apb(0, 8'h00, 0); `CHK("ctrl", 32'h0000024F, rd)
        `CHK("floor", 4'h2, floorSet)
        apb(0, 8'h08, 0); `CHK("slverr", 1'b1, err)
        // only lane1 strobed: floor changes, low byte keeps its reset value
        strb <= 4'h2;
        apb(1, 8'h00, 32'h00000F00);
        apb(0, 8'h00, 0); `CHK("lane", 32'h00000F4F, rd)
        `CHK("floorf", 4'hF, floorSet)
        strb <= 4'hF;
        $display("test reset done");
        // zones run with the timer off so it cannot expire meanwhile
        apb(1, 8'h00, 32'h0000024D);
        chgEnN <= 1'b0;
        wt(20); `CHK("chg", 1'b1, chargeOn)
        tsCool <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            apb(1, 8'h00, 32'h0000020D | (c << 6));
            wt(12); `CHK("pct", pctTab[c], pct)
            `CHK("term", 1'b1, termEn)
        end
        tsCool <= 1'b0;
        tsWarm <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            apb(1, 8'h00, 32'h0000024D | (w << 4));
            wt(12); `CHK("warmchg", 1'(w != 3), chargeOn)
            if (w < 3) `CHK("volt", voltTab[w], voltCode)
        end
        apb(1, 8'h00, 32'h0000024D);
        tsHot <= 1'b1;
        {boost, buck} <= 2'b00;
        wt(12); `CHK("idle", 1'b1, chargeOn)
        boost <= 1'b1;
        wt(12); `CHK("hot", 1'b0, chargeOn)
        {tsHot, tsWarm} <= 2'b00;
        wt(12); `CHK("back", 1'b1, chargeOn)
        {tsCold, tsCool} <= 2'b11;
        wt(12); `CHK("cold", 1'b0, chargeOn)
        {tsCold, tsCool} <= 2'b00;
        belowVreg <= 1'b0;
        restart();
        wt(12); `CHK("full", 1'b0, chargeOn)
        belowVreg <= 1'b1;
        $display("test zones done");
        otgMode <= 1'b1;
        wt(12); `CHK("otg", 1'b1, otgEn)
        otgHot <= 1'b1;
        wt(12); `CHK("otgoff", 1'b0, otgEn)
        `CHK("iss", 3'h0, iss)
        `CHK("tzs", 3'h6, tzs)
        otgHot <= 1'b0;
        wt(12); `CHK("otgon", 1'b1, otgEn)
        `CHK("tzsn", 3'h0, tzs)
        `CHK("issotg", 3'h7, iss)
        otgCold <= 1'b1;
        wt(12); `CHK("tzsc", 3'h5, tzs)
        `CHK("otgcold", 1'b0, otgEn)
        otgCold <= 1'b0;
        wt(12); `CHK("otgback", 1'b1, otgEn)
        otgMode <= 1'b0;
        srcType <= 3'h5;
        {vinReg, iinReg, floorAct} <= 3'b111;
        wt(4);
        apb(1, 8'h00, 32'h00000249);
        apb(0, 8'h04, 0); `CHK("sts", 3'h7, rd[3:1])
        `CHK("src", 3'h5, iss)
        apb(0, 8'h00, 0); `CHK("slow", 32'h0000024D, rd)
        {vinReg, iinReg, floorAct} <= 3'b000;
        $display("test status done");
        wt(150); `CHK("tmroff", 1'b1, batSw)
        apb(1, 8'h00, 32'h0000024F);
        restart();
        wt(60); `CHK("early", 1'b1, batSw)
        waitOff(80); `CHK("expire", 1'b0, batSw)
        base = pulses;
        wt(4);
        apb(0, 8'h04, 0); `CHK("tmrsts", 1'b1, rd[0])
        `CHK("block", 1'b0, chargeOn)
        wt(20); `CHK("irq", 1'b1, pulses > base)
        `CHK("irqw", 8, width)
        thermReg <= 1'b1;
        restart();
        wt(130); `CHK("half", 1'b1, batSw)
        waitOff(150); `CHK("halfexp", 1'b0, batSw)
        thermReg <= 1'b0;
        apb(1, 8'h00, 32'h0000024B);
        thermReg <= 1'b1;
        restart();
        wt(60); `CHK("fullr", 1'b1, batSw)
        waitOff(80); `CHK("fullexp", 1'b0, batSw)
        thermReg <= 1'b0;
        restart();
        wt(60);
        recharge <= 1'b1;
        wt(1);
        recharge <= 1'b0;
        wt(60); `CHK("rech", 1'b1, batSw)
        // supplement then a charge fault hold the count well past the limit
        restart();
        wt(40);
        supp <= 1'b1;
        wt(50);
        supp <= 1'b0;
        fault <= 1'b1;
        wt(50); `CHK("pause", 1'b1, batSw)
        `CHK("fltoff", 1'b0, chargeOn)
        fault <= 1'b0;
        waitOff(80); `CHK("resume", 1'b0, batSw)
        belowLow <= 1'b1;
        restart();
        wt(30); `CHK("pre", 1'b1, batSw)
        waitOff(40); `CHK("preexp", 1'b0, batSw)
        $display("test timers done");
        summarize();
    end
endmodule
